// ---- design/ctrxc_defs.svh ----
// Constants for the contactless target receive/transmit control block
// Contract
// - Wait bit ends anticollision after select+command
// - Polling sequence plus command also ends it
// - Wait bit set blocks active communication
// - 424 kbit slot halved when bit set
// - Drop packets longer than four times limit
// - Limit field zero means 256 bytes
// - 106 kbit skips check without sync detection
// - Bits 7..5 set Miller decoder sensitivity
// - Bits 4..3 set Miller time constant
// - Halted card accepts only request 52h; the filter acts at 106 kbit only
// - Halted flag set by host or engine
// - RF field reset clears halted flag
// - Response time is 7 plus wait bits
// - Early transmit request waits for minimum time
// - Late request starts once bit phase aligned
// - Reset values 62h and 00h, all writable
`ifndef CTRXC_DEFS_SVH
`define CTRXC_DEFS_SVH
// ==========================================
// Register map
`define CTRXC_ADDR_PLSC        6'h1b
`define CTRXC_ADDR_MRC         6'h1c
`define CTRXC_RST_PLSC         8'h00
`define CTRXC_RST_MRC          8'h62
// ==========================================
// Field positions
`define CTRXC_BIT_HOLD_SEL     7
`define CTRXC_BIT_HALF_SLOT    6
`define CTRXC_QUADS_HI         5
`define CTRXC_SENS_HI          7
`define CTRXC_SENS_LO          5
`define CTRXC_TAU_HI           4
`define CTRXC_TAU_LO           3
`define CTRXC_BIT_HALTED       2
`define CTRXC_WAIT_HI          1
// ==========================================
// Protocol values
`define CTRXC_REQ_HALTED_OK    8'h52
`define CTRXC_LEN_UNLIMITED    9'h100
`define CTRXC_BASE_WAIT_BITS   4'h7
// Slot length at 212 kbit, in data bits (plain default)
`define CTRXC_SLOT_212_BITS    8'h80
`endif

// ---- design/ctrxc_pkg.sv ----
// Types for the contactless target receive/transmit control block
package ctrxc_pkg;
  typedef enum logic [1:0] {
    CTRXC_RATE_106 = 2'b00,
    CTRXC_RATE_212 = 2'b01,
    CTRXC_RATE_424 = 2'b10
  } ctrxc_rate_t;
  typedef enum logic [1:0] {
    CTRXC_AC_IDLE   = 2'b00,
    CTRXC_AC_WAIT   = 2'b01,
    CTRXC_AC_ARMED  = 2'b10
  } ctrxc_ac_t;
  typedef enum logic [1:0] {
    CTRXC_TX_IDLE   = 2'b00,
    CTRXC_TX_GUARD  = 2'b01,
    CTRXC_TX_HOLD   = 2'b10
  } ctrxc_tx_t;
endpackage

// ---- design/ctrxc_len_check.sv ----
// Receive packet length limit check
`timescale 1ns/10ps
`default_nettype none
`include "ctrxc_defs.svh"
module ctrxc_len_check
  import ctrxc_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [5:0]  i_max_quads,
  input  wire ctrxc_rate_t i_rate,
  input  wire logic        i_sync_det_en,
  input  wire logic        i_rx_byte_valid,
  input  wire logic        i_rx_end,
  output logic             o_too_long
);
  logic [8:0] limit;
  logic       bypass;
  logic [9:0] cnt_ff;
  logic       over_ff;

  // Zero field means the 256 byte ceiling
  assign limit  = (i_max_quads == 6'h00) ? `CTRXC_LEN_UNLIMITED : {1'b0, i_max_quads, 2'b00};
  assign bypass = (i_rate == CTRXC_RATE_106) && !i_sync_det_en;

  // Byte counter, saturates so long frames cannot wrap back under the limit
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_rx_end) begin
      cnt_ff <= 10'h000;
    end else if (i_rx_byte_valid && !cnt_ff[9]) begin
      cnt_ff <= cnt_ff + 10'h001;
    end
  end

  // Sticky overrun for the frame in progress
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_rx_end) begin
      over_ff <= 1'b0;
    end else if (i_rx_byte_valid && !bypass && ((cnt_ff + 10'h001) > {1'b0, limit})) begin
      over_ff <= 1'b1;
    end
  end

  assign o_too_long = over_ff || (i_rx_byte_valid && !bypass && ((cnt_ff + 10'h001) > {1'b0, limit}));
endmodule
`default_nettype wire

// ---- design/ctrxc_tx_guard.sv ----
// Minimum receive-to-transmit response time guard
`timescale 1ns/10ps
`default_nettype none
`include "ctrxc_defs.svh"
module ctrxc_tx_guard
  import ctrxc_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [1:0] i_wait_bits,
  input  wire logic       i_rx_end,
  input  wire logic       i_bit_tick,
  input  wire logic       i_phase_ok,
  input  wire logic       i_tx_req,
  output logic            o_tx_start,
  output logic            o_waiting
);
  ctrxc_tx_t  state_ff;
  ctrxc_tx_t  nxt_state;
  logic [3:0] bits_ff;
  logic       pend_ff;
  logic       elapsed;

  assign elapsed = (bits_ff >= (`CTRXC_BASE_WAIT_BITS + {2'b00, i_wait_bits}));

  // Guard state follows end of reception and elapsed bit count
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CTRXC_TX_IDLE:  nxt_state = i_rx_end ? CTRXC_TX_GUARD : CTRXC_TX_IDLE;
      CTRXC_TX_GUARD: nxt_state = elapsed ? CTRXC_TX_HOLD : CTRXC_TX_GUARD;
      CTRXC_TX_HOLD:  nxt_state = i_rx_end ? CTRXC_TX_GUARD : CTRXC_TX_HOLD;
      default:        nxt_state = CTRXC_TX_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_ff <= CTRXC_TX_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Data bit counter since end of reception
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_rx_end) begin
      bits_ff <= 4'h0;
    end else if (state_ff == CTRXC_TX_GUARD && i_bit_tick && !elapsed) begin
      bits_ff <= bits_ff + 4'h1;
    end
  end

  // A request may come early; it is remembered until it can go
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || o_tx_start) begin
      pend_ff <= 1'b0;
    end else if (i_tx_req) begin
      pend_ff <= 1'b1;
    end
  end

  // Start only after guard time and on aligned bit phase
  assign o_tx_start = (pend_ff || i_tx_req) && (state_ff != CTRXC_TX_GUARD) && i_phase_ok;
  assign o_waiting  = (pend_ff || i_tx_req) && !o_tx_start;
endmodule
`default_nettype wire

// ---- design/ctrxc_top.sv ----
// Target-mode receive/transmit control registers and their logic
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "ctrxc_defs.svh"
module ctrxc_top
  import ctrxc_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // Register port
  input  wire logic [5:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [7:0]       o_reg_rdata,
  // Mode and framing context
  input  wire ctrxc_rate_t i_rate,
  input  wire logic        i_sync_detection_enable,
  input  wire logic        i_card_mode,
  input  wire logic        i_rf_field_reset,
  input  wire logic        i_auto_anticollision_command,
  input  wire logic        i_select_done,
  input  wire logic        i_polling_done,
  input  wire logic        i_engine_halt,
  input  wire logic        i_active_req,
  // Receive path
  input  wire logic        i_rx_byte_valid,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic        i_rx_first,
  input  wire logic        i_rx_end,
  input  wire logic        i_rx_crc_ok,
  // Transmit path
  input  wire logic        i_bit_tick,
  input  wire logic        i_transmit_bit_phase_ok,
  input  wire logic        i_tx_req,
  // Outputs
  output logic             o_rx_wr,
  output logic [7:0]       o_rx_data,
  output logic             o_rx_flush,
  output logic             o_cmd_valid,
  output logic             o_req_ignored,
  output logic             o_auto_anticollision_command_done,
  output logic             o_active_allowed,
  output logic [7:0]       o_slot_len_bits,
  output logic [2:0]       o_miller_decoder_sensitivity,
  output logic [1:0]       o_miller_decoder_time_constant,
  output logic             o_tx_start,
  output logic             o_tx_waiting
);
  // ==========================================
  // Registers
  logic [7:0] plsc_ff;
  logic [7:0] mrc_ff;
  logic       halted_ff;
  ctrxc_ac_t  ac_ff;
  ctrxc_ac_t  nxt_ac;
  logic       too_long;
  logic       drop_ff;
  logic       bad_first;
  logic [1:0] sel;
  // Reset image of the tuning register, sliced for per-field reset values
  localparam logic [7:0] RST_MRC = `CTRXC_RST_MRC;
  logic       filt_ff;
  logic       tx_start;
  logic       tx_wait;
  logic       frame_ok;

  // Address decode shared by read and write paths
  function automatic logic [1:0] dec(input logic [5:0] a);
    dec = {(a == `CTRXC_ADDR_MRC), (a == `CTRXC_ADDR_PLSC)};
  endfunction

  // One decode for all users; a function result cannot be bit-selected
  assign sel = dec(i_reg_addr);

  // Host-writable configuration
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      plsc_ff <= `CTRXC_RST_PLSC;
      mrc_ff  <= `CTRXC_RST_MRC;
    end else if (i_reg_wr) begin
      if (sel[0]) begin
        plsc_ff <= i_reg_wdata;
      end
      if (sel[1]) begin
        mrc_ff <= i_reg_wdata;
      end
    end
  end

  // Halted flag: host or engine set, RF reset clears; a set beats the clear
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      halted_ff <= RST_MRC[`CTRXC_BIT_HALTED];
    end else if (i_engine_halt) begin
      halted_ff <= 1'b1;
    end else if (i_reg_wr && sel[1]) begin
      halted_ff <= i_reg_wdata[`CTRXC_BIT_HALTED];
    end else if (i_rf_field_reset) begin
      halted_ff <= 1'b0;
    end
  end

  // Read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd && sel[0]) begin
      o_reg_rdata <= plsc_ff;
    end else if (i_reg_rd && sel[1]) begin
      o_reg_rdata <= {mrc_ff[`CTRXC_SENS_HI:`CTRXC_TAU_LO], halted_ff, mrc_ff[`CTRXC_WAIT_HI:0]};
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // ==========================================
  // Receive filtering
  ctrxc_len_check u_len (
    .i_core_clk      (i_core_clk),
    .i_sys_rst       (i_sys_rst),
    .i_max_quads     (plsc_ff[`CTRXC_QUADS_HI:0]),
    .i_rate          (i_rate),
    .i_sync_det_en   (i_sync_detection_enable),
    .i_rx_byte_valid (i_rx_byte_valid),
    .i_rx_end        (i_rx_end),
    .o_too_long      (too_long)
  );

  // Halted card at 106 kbit: first byte must be the allowed request code
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_rx_end) begin
      filt_ff <= 1'b0;
    end else if (bad_first) begin
      filt_ff <= 1'b1;
    end
  end

  assign bad_first = i_rx_byte_valid && i_rx_first && halted_ff && i_card_mode && i_rate == CTRXC_RATE_106
                     && i_rx_byte != `CTRXC_REQ_HALTED_OK;

  // Drop latch: once a frame is rejected, no more bytes pass
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_rx_end) begin
      drop_ff <= 1'b0;
    end else if (too_long || bad_first) begin
      drop_ff <= 1'b1;
    end
  end

  // Bytes reach the buffer only while the frame is good
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_rx_wr   <= 1'b0;
      o_rx_data <= 8'h00;
    end else begin
      o_rx_wr   <= i_rx_byte_valid && !too_long && !drop_ff && !bad_first;
      o_rx_data <= i_rx_byte;
    end
  end

  assign frame_ok = i_rx_end && i_rx_crc_ok && !too_long && !drop_ff && !filt_ff;

  // Flush partial bytes of a rejected frame; no command reported
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_rx_flush    <= 1'b0;
      o_cmd_valid   <= 1'b0;
      o_req_ignored <= 1'b0;
    end else begin
      o_rx_flush    <= i_rx_end && (too_long || drop_ff || filt_ff);
      o_cmd_valid   <= frame_ok;
      o_req_ignored <= i_rx_end && filt_ff;
    end
  end

  // ==========================================
  // Anticollision termination
  always_comb begin
    nxt_ac = ac_ff;
    case (ac_ff)
      CTRXC_AC_IDLE:  nxt_ac = i_auto_anticollision_command ? CTRXC_AC_WAIT : CTRXC_AC_IDLE;
      CTRXC_AC_WAIT:  nxt_ac = !i_auto_anticollision_command ? CTRXC_AC_IDLE :
                               (i_select_done || i_polling_done) ? CTRXC_AC_ARMED : CTRXC_AC_WAIT;
      CTRXC_AC_ARMED: nxt_ac = (!i_auto_anticollision_command || frame_ok) ? CTRXC_AC_IDLE : CTRXC_AC_ARMED;
      default:        nxt_ac = CTRXC_AC_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ac_ff <= CTRXC_AC_IDLE;
    end else begin
      ac_ff <= nxt_ac;
    end
  end

  // Without the hold bit, any valid command ends the command
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_auto_anticollision_command_done <= 1'b0;
    end else if (plsc_ff[`CTRXC_BIT_HOLD_SEL]) begin
      o_auto_anticollision_command_done <= ac_ff == CTRXC_AC_ARMED && frame_ok && i_auto_anticollision_command;
    end else begin
      o_auto_anticollision_command_done <= i_auto_anticollision_command && frame_ok;
    end
  end

  // Active mode is locked out while holding for selection
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_active_allowed <= 1'b0;
    end else begin
      o_active_allowed <= i_active_req && !plsc_ff[`CTRXC_BIT_HOLD_SEL];
    end
  end

  // Slot length: half of the 212 kbit slot only at 424 kbit
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_slot_len_bits <= `CTRXC_SLOT_212_BITS;
    end else if (i_rate == CTRXC_RATE_424 && plsc_ff[`CTRXC_BIT_HALF_SLOT]) begin
      o_slot_len_bits <= `CTRXC_SLOT_212_BITS >> 1;
    end else begin
      o_slot_len_bits <= `CTRXC_SLOT_212_BITS;
    end
  end

  // Miller decoder tuning straight from the register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_miller_decoder_sensitivity   <= RST_MRC[`CTRXC_SENS_HI:`CTRXC_SENS_LO];
      o_miller_decoder_time_constant <= RST_MRC[`CTRXC_TAU_HI:`CTRXC_TAU_LO];
    end else begin
      o_miller_decoder_sensitivity   <= mrc_ff[`CTRXC_SENS_HI:`CTRXC_SENS_LO];
      o_miller_decoder_time_constant <= mrc_ff[`CTRXC_TAU_HI:`CTRXC_TAU_LO];
    end
  end

  // ==========================================
  // Response timing
  ctrxc_tx_guard u_guard (
    .i_core_clk  (i_core_clk),
    .i_sys_rst   (i_sys_rst),
    .i_wait_bits (mrc_ff[`CTRXC_WAIT_HI:0]),
    .i_rx_end    (i_rx_end),
    .i_bit_tick  (i_bit_tick),
    .i_phase_ok  (i_transmit_bit_phase_ok),
    .i_tx_req    (i_tx_req),
    .o_tx_start  (tx_start),
    .o_waiting   (tx_wait)
  );

  // Registered so the frame start leaves a flip-flop
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_tx_start   <= 1'b0;
      o_tx_waiting <= 1'b0;
    end else begin
      o_tx_start   <= tx_start;
      o_tx_waiting <= tx_wait;
    end
  end
endmodule
`default_nettype wire

// ---- tb/ctrxc_chk.sv ----
// Port-level assertion checker for the target receive/transmit control block
`timescale 1ns/10ps
`default_nettype none
module ctrxc_chk
  import ctrxc_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic [5:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  o_reg_rdata,
  input wire ctrxc_rate_t i_rate,
  input wire logic        i_sync_detection_enable,
  input wire logic        i_card_mode,
  input wire logic        i_rx_byte_valid,
  input wire logic        i_rx_first,
  input wire logic        i_rx_end,
  input wire logic        i_rx_crc_ok,
  input wire logic        i_bit_tick,
  input wire logic        o_rx_flush,
  input wire logic        o_cmd_valid,
  input wire logic        o_active_allowed,
  input wire logic [7:0]  o_slot_len_bits,
  input wire logic [2:0]  o_miller_decoder_sensitivity,
  input wire logic [1:0]  o_miller_decoder_time_constant,
  input wire logic        o_tx_start
);
  // ========
  // Helper state
  logic [7:0] plsc_ff;
  logic [7:0] mrc_ff;
  logic [9:0] len_ff;
  logic [3:0] tick_ff;
  logic [9:0] lim;
  logic       over;
  logic       bypass;
  logic [3:0] wmin;
  // Host shadow only; the halted bit is moved by the engine too, so never compared
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      plsc_ff <= 8'h00;
      mrc_ff  <= 8'h62;
    end else if (i_reg_wr && i_reg_addr == 6'h1b) begin
      plsc_ff <= i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == 6'h1c) begin
      mrc_ff  <= i_reg_wdata;
    end
  end
  // Frame length and bit ticks since frame end; ticks saturate at 15
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      len_ff  <= 10'h000;
      tick_ff <= 4'hf;
    end else begin
      if (i_rx_byte_valid) len_ff <= i_rx_first ? 10'h001 : len_ff + 10'h001;
      if (i_rx_end) tick_ff <= 4'h0;
      else if (i_bit_tick && tick_ff != 4'hf) tick_ff <= tick_ff + 4'h1;
    end
  end
  // Limit in bytes and the 106 kbit bypass
  assign lim    = (plsc_ff[5:0] == 6'h00) ? 10'h100 : {2'b00, plsc_ff[5:0], 2'b00};
  assign over   = len_ff > lim;
  assign bypass = (i_rate == CTRXC_RATE_106) && !i_sync_detection_enable;
  assign wmin   = 4'h7 + {2'b00, mrc_ff[1:0]};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // ========
  // Properties
  property p_rd_idle;
    !i_reg_rd |=> o_reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  property p_rd_plsc;
    i_reg_rd && i_reg_addr == 6'h1b |=> o_reg_rdata == plsc_ff;
  endproperty
  a_rd_plsc: assert property (p_rd_plsc) else $error("limit register read wrong");
  property p_active;
    plsc_ff[7] && $past(plsc_ff[7]) |-> !o_active_allowed;
  endproperty
  a_active: assert property (p_active) else $error("active mode allowed while holding");
  property p_slot;
    $stable(plsc_ff) && $stable(i_rate) && i_rate == CTRXC_RATE_424 && plsc_ff[6] |-> o_slot_len_bits == 8'h40;
  endproperty
  a_slot: assert property (p_slot) else $error("short slot not half length");
  property p_sens;
    $stable(mrc_ff) |-> o_miller_decoder_sensitivity == mrc_ff[7:5];
  endproperty
  a_sens: assert property (p_sens) else $error("decoder sensitivity wrong");
  property p_tau;
    $stable(mrc_ff) |-> o_miller_decoder_time_constant == mrc_ff[4:3];
  endproperty
  a_tau: assert property (p_tau) else $error("decoder time constant wrong");
  property p_len_drop;
    i_rx_end && over && !bypass |=> o_rx_flush && !o_cmd_valid;
  endproperty
  a_len_drop: assert property (p_len_drop) else $error("oversize frame kept");
  property p_len_keep;
    i_rx_end && i_rx_crc_ok && !i_card_mode && (!over || bypass) |=> o_cmd_valid && !o_rx_flush;
  endproperty
  a_len_keep: assert property (p_len_keep) else $error("frame within limit dropped");
  property p_tx_min;
    o_tx_start |-> tick_ff >= wmin;
  endproperty
  a_tx_min: assert property (p_tx_min) else $error("frame sent before response time");
  c_flush: cover property (o_rx_flush);
  c_cmd: cover property (o_cmd_valid);
  c_tx: cover property (o_tx_start);
endmodule
bind ctrxc_top ctrxc_chk chk_u (
  .i_core_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
  .i_rate, .i_sync_detection_enable, .i_card_mode, .i_rx_byte_valid, .i_rx_first, .i_rx_end,
  .i_rx_crc_ok, .i_bit_tick, .o_rx_flush, .o_cmd_valid, .o_active_allowed, .o_slot_len_bits,
  .o_miller_decoder_sensitivity, .o_miller_decoder_time_constant, .o_tx_start
);
`default_nettype wire

// ---- tb/tb_reader.sv ----
// Behavioural remote reader: frames and data-bit ticks toward the block
`timescale 1ns/10ps
`default_nettype none
module tb_reader (
  input  wire logic  i_core_clk,
  output logic       o_byte_valid,
  output logic [7:0] o_byte,
  output logic       o_first,
  output logic       o_end,
  output logic       o_crc_ok,
  output logic       o_tick
);
  // ========
  // Idle line state
  initial begin
    o_byte_valid = 1'b0;
    o_byte       = 8'h00;
    o_first      = 1'b0;
    o_end        = 1'b0;
    o_crc_ok     = 1'b0;
    o_tick       = 1'b0;
  end
  // Frame of n bytes with good check, first byte b0
  task automatic frame(input int n, input logic [7:0] b0);
    for (int i = 0; i < n; i++) begin
      @(posedge i_core_clk);
      o_byte_valid <= 1'b1;
      o_first      <= (i == 0);
      o_byte       <= (i == 0) ? b0 : i[7:0];
    end
    @(posedge i_core_clk);
    o_byte_valid <= 1'b0;
    o_first      <= 1'b0;
    o_byte       <= ~o_byte; // Released lines never echo the last byte
    o_end        <= 1'b1;
    o_crc_ok     <= 1'b1;
    @(posedge i_core_clk);
    o_end        <= 1'b0;
    o_crc_ok     <= 1'b0;
  endtask
  // Data-bit ticks with an idle cycle between them
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      o_tick <= 1'b1;
      @(posedge i_core_clk);
      o_tick <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the target receive/transmit control block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ctrxc_pkg::*;
;
  // ========
  // Signals
  logic        i_core_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [5:0]  i_reg_addr = 6'h00;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  ctrxc_rate_t i_rate = CTRXC_RATE_212;
  logic        i_sync_detection_enable = 1'b0;
  logic        i_card_mode = 1'b0;
  logic        i_auto_anticollision_command = 1'b0;
  logic        i_active_req = 1'b0;
  logic        i_transmit_bit_phase_ok = 1'b0;
  logic [4:0]  ev = 5'h00; // Select, polling, halt, field reset, transmit request
  logic        i_rx_byte_valid, i_rx_first, i_rx_end, i_rx_crc_ok, i_bit_tick;
  logic [7:0]  i_rx_byte, o_reg_rdata, o_slot_len_bits, o_rx_data, last_wr;
  logic        o_rx_wr, o_rx_flush, o_cmd_valid, o_req_ignored, o_auto_anticollision_command_done;
  logic        o_active_allowed, o_tx_start, o_tx_waiting;
  logic [2:0]  o_miller_decoder_sensitivity;
  logic [1:0]  o_miller_decoder_time_constant;
  logic [5:0]  pv;
  int          cnt [6];
  int          base [6];
  int          errors = 0;
  int          total_checks = 0;
  ctrxc_top dut_u (
    .i_core_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_rate, .i_sync_detection_enable, .i_card_mode, .i_rf_field_reset(ev[3]),
    .i_auto_anticollision_command, .i_select_done(ev[0]), .i_polling_done(ev[1]),
    .i_engine_halt(ev[2]), .i_active_req, .i_rx_byte_valid, .i_rx_byte, .i_rx_first,
    .i_rx_end, .i_rx_crc_ok, .i_bit_tick, .i_transmit_bit_phase_ok, .i_tx_req(ev[4]),
    .o_rx_wr, .o_rx_data, .o_rx_flush, .o_cmd_valid, .o_req_ignored, .o_auto_anticollision_command_done,
    .o_active_allowed, .o_slot_len_bits, .o_miller_decoder_sensitivity,
    .o_miller_decoder_time_constant, .o_tx_start, .o_tx_waiting
  );
  tb_reader rdr_u (
    .i_core_clk, .o_byte_valid(i_rx_byte_valid), .o_byte(i_rx_byte), .o_first(i_rx_first),
    .o_end(i_rx_end), .o_crc_ok(i_rx_crc_ok), .o_tick(i_bit_tick)
  );
  always #5 i_core_clk = ~i_core_clk;
  // One-cycle outputs are counted so no pulse is missed between checks
  assign pv = {o_tx_start, o_auto_anticollision_command_done, o_req_ignored, o_cmd_valid, o_rx_flush, o_rx_wr};
  always @(posedge i_core_clk) begin
    for (int k = 0; k < 6; k++) if (pv[k] === 1'b1) cnt[k]++;
    if (o_rx_wr === 1'b1) last_wr = o_rx_data; // Last byte handed to the buffer
  end
  // ========
  // Helpers
  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic pulse(input int k);
    @(posedge i_core_clk);
    ev[k] <= 1'b1;
    @(posedge i_core_clk);
    ev[k] <= 1'b0;
  endtask
  task automatic mark;
    base = cnt;
  endtask
  // Pulses of kind i since the last mark, after the frame has settled
  task automatic dlt(input int i, input int d);
    check(16'(cnt[i] - base[i]), 16'(d));
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd   <= 1'b0;
    // Data stood since the last edge; taken at the edge that ends its cycle
    @(posedge i_core_clk);
    check(16'(o_reg_rdata), 16'(exp));
  endtask
  task automatic fr(input int n, input logic [7:0] b0);
    mark;
    rdr_u.frame(n, b0);
    cyc(4);
  endtask
  // ========
  // Scenarios
  task automatic t_regs;
    rd(6'h1b, 8'h00);
    rd(6'h1c, 8'h62);
    wr(6'h1b, 8'h5a);
    rd(6'h1b, 8'h5a);
    rd(6'h3f, 8'h00);
    wr(6'h1c, 8'hb1);
    rd(6'h1c, 8'hb1);
    check(16'(o_miller_decoder_sensitivity), 16'h0005);
    check(16'(o_miller_decoder_time_constant), 16'h0002);
    i_rate <= CTRXC_RATE_424;
    wr(6'h1b, 8'h40);
    cyc(2);
    check(16'(o_slot_len_bits), 16'h0040);
    wr(6'h1b, 8'h00);
    cyc(2);
    check(16'(o_slot_len_bits), 16'h0080);
    i_rate <= CTRXC_RATE_212;
    wr(6'h1c, 8'h62);
  endtask
  task automatic t_len;
    wr(6'h1b, 8'h01);
    fr(5, 8'h10);
    dlt(0, 4);
    dlt(1, 1);
    dlt(2, 0);
    check(16'(last_wr), 16'h0003);
    fr(4, 8'h10);
    dlt(2, 1);
    wr(6'h1b, 8'h00);
    fr(256, 8'h10);
    dlt(2, 1);
    fr(257, 8'h10);
    dlt(1, 1);
    dlt(0, 256);
    wr(6'h1b, 8'h01);
    i_rate <= CTRXC_RATE_106;
    fr(5, 8'h10);
    dlt(2, 1);
    i_sync_detection_enable <= 1'b1;
    fr(5, 8'h10);
    dlt(1, 1);
    i_sync_detection_enable <= 1'b0;
    wr(6'h1b, 8'h00);
  endtask
  task automatic t_halt;
    i_card_mode <= 1'b1;
    wr(6'h1c, 8'h66);
    rd(6'h1c, 8'h66);
    fr(3, 8'h26);
    dlt(3, 1);
    dlt(0, 0);
    dlt(2, 0);
    fr(3, 8'h52);
    dlt(2, 1);
    pulse(3);
    rd(6'h1c, 8'h62);
    pulse(2);
    rd(6'h1c, 8'h66);
    wr(6'h1c, 8'h62);
    i_card_mode <= 1'b0;
    i_rate <= CTRXC_RATE_212;
  endtask
  task automatic t_acol;
    wr(6'h1b, 8'h80);
    i_active_req <= 1'b1;
    i_auto_anticollision_command <= 1'b1;
    cyc(3);
    check(16'(o_active_allowed), 16'h0000);
    fr(1, 8'h93);
    dlt(4, 0);
    pulse(0);
    fr(1, 8'h93);
    dlt(4, 1);
    i_auto_anticollision_command <= 1'b0;
    cyc(2);
    i_auto_anticollision_command <= 1'b1;
    pulse(1);
    fr(1, 8'h06);
    dlt(4, 1);
    i_auto_anticollision_command <= 1'b0;
    wr(6'h1b, 8'h00);
    cyc(3);
    check(16'(o_active_allowed), 16'h0001);
    i_active_req <= 1'b0;
  endtask
  // Longest wait: nine bits must not release the frame, the tenth must
  task automatic t_tx;
    wr(6'h1c, 8'h63);
    i_transmit_bit_phase_ok <= 1'b1;
    fr(1, 8'h30);
    pulse(4);
    mark;
    rdr_u.ticks(9);
    cyc(3);
    dlt(5, 0);
    check(16'(o_tx_waiting), 16'h0001);
    rdr_u.ticks(1);
    cyc(4);
    dlt(5, 1);
    i_transmit_bit_phase_ok <= 1'b0;
    fr(1, 8'h30);
    rdr_u.ticks(12);
    mark;
    pulse(4);
    cyc(4);
    dlt(5, 0);
    i_transmit_bit_phase_ok <= 1'b1;
    cyc(4);
    dlt(5, 1);
  endtask
  // ========
  // Main sequence and watchdog
  initial begin
    cyc(3);
    i_sys_rst <= 1'b0;
    t_regs;
    t_len;
    t_halt;
    t_acol;
    t_tx;
    complete_run;
  end
  initial begin
    #100000;
    errors++;
    complete_run;
  end
endmodule
`default_nettype wire
